/* verilog/ssc_defs.vh */
// Purpose: shared constants for the soft error status controller
// Assumes: included by bare name from every design file
// Notes:   definitions only, no logic
`ifndef SSC_DEFS_VH
`define SSC_DEFS_VH

// ----------------------------------------------------------------------
// widths and timing
// ----------------------------------------------------------------------
`define SSC_ICAP_W 32
`define SSC_FAR_W 26
`define SSC_HB_PERIOD 64
`define SSC_RD_LAT 3
`define SSC_RST_LEN 8

// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define SSC_A_CTRL 8'h00
`define SSC_A_CMD 8'h04
`define SSC_A_INJ 8'h08
`define SSC_A_STAT 8'h0C
`define SSC_A_FAR 8'h10
`define SSC_A_ELO 8'h14
`define SSC_A_EHI 8'h18
`define SSC_A_INIT 8'h1C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SSC_B_CORR_EN 0
`define SSC_B_CLASS_EN 1
`define SSC_B_GO_IDLE 0
`define SSC_B_RESUME 1
`define SSC_B_INJECT 2
`define SSC_B_UNCORR 5
`define SSC_B_ESS 6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SSC_CTRL_RST 2'h3
`define SSC_WORD_RST 32'h0000_0000
`define SSC_ZERO_ST 5'h00
`define SSC_CNT_ZERO 4'h0

`endif

/* verilog/ssc_rst_gen.v */
// Purpose: internal synchronous reset made from global set/reset release
// Assumes: global_set_reset is the asynchronous rst input
// Notes:   holds srst for RST_LEN clocks after release
`timescale 1ns/1ps
`include "ssc_defs.vh"

module ssc_rst_gen #(
    parameter RST_LEN = `SSC_RST_LEN
) (
    // clock and global set/reset
    input wire clk_sys,
    input wire rst,
    // internal synchronous reset
    output reg srst_reg
);

// ----------------------------------------------------------------------
// release counter
// ----------------------------------------------------------------------
reg [7:0] cnt_reg; // cycles counted since release

// counts only after the global reset lets go, so every flip-flop
// sees RST_LEN clocked reset cycles
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cnt_reg <= 8'h00;
        srst_reg <= 1'b1;
    end else if (cnt_reg != RST_LEN[7:0] - 8'h01) begin
        cnt_reg <= cnt_reg + 8'h01; // R1
        srst_reg <= 1'b1;
    end else begin
        srst_reg <= 1'b0; // R1
    end
end

endmodule

/* verilog/ssc_beat.v */
// Purpose: heartbeat pulse generator for the status outputs
// Assumes: enable is a registered level in the same clock domain
// Notes:   PERIOD must not exceed 128 cycles
`timescale 1ns/1ps
`include "ssc_defs.vh"

module ssc_beat #(
    parameter PERIOD = `SSC_HB_PERIOD
) (
    // clock and resets
    input wire clk_sys,
    input wire rst,
    input wire srst,
    // control
    input wire enable,
    // one-cycle pulse
    output reg beat_reg
);

// ----------------------------------------------------------------------
// period counter
// ----------------------------------------------------------------------
reg [7:0] cnt_reg; // position in the period

// free running while enabled; restarts on enable so the first pulse
// still comes within one period of observation starting
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        cnt_reg <= 8'h00;
        beat_reg <= 1'b0;
    end else if (srst || !enable) begin
        cnt_reg <= 8'h00;
        beat_reg <= 1'b0;
    end else if (cnt_reg == PERIOD[7:0] - 8'h01) begin
        cnt_reg <= 8'h00;
        beat_reg <= 1'b1; // R9
    end else begin
        cnt_reg <= cnt_reg + 8'h01;
        beat_reg <= 1'b0;
    end
end

endmodule

/* verilog/ssc_top.v */
// Purpose: state, status and configuration-port control of the soft
//          error controller
// Assumes: one clock clk_sys; rst is the global set/reset
// Notes:   registers on a plain strobe port, read data one cycle later
//
// How it works
// R1 - internal sync reset after global release
// R2 - single rising-edge clock for everything
// R3 - 32-bit port read and write buses
// R4 - active-low chip select and read/write
// R5 - integrator feeds same clock to port
// R6 - integrator leaves request output open
// R7 - stay initializing while grant is low
// R8 - accept all scan checker inputs
// R9 - heartbeat pulse within 128 cycles observing
// R10 - heartbeat unspecified outside observation
// R11 - initialization indicator, once after start
// R12 - observation indicator, also while querying
// R13 - correction indicator, even when disabled
// R14 - classification indicator, even when disabled
// R15 - injection indicator until injection done
// R16 - essential flag set before leaving classification
// R17 - uncorrectable flag set before leaving correction
// R18 - idle shows all five indicators low
// R19 - halted shows all five indicators high
// R20 - injection indicator acknowledges accepted command
// R21 - otherwise exactly one indicator high
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ssc_defs.vh"

module ssc_top #(
    parameter ICAP_W = `SSC_ICAP_W,
    parameter FAR_W = `SSC_FAR_W,
    parameter RD_LAT = `SSC_RD_LAT,
    parameter HB_PERIOD = `SSC_HB_PERIOD,
    parameter RST_LEN = `SSC_RST_LEN
) (
    // clock and global set/reset
    input wire clk_sys,
    input wire rst,
    // register port
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // configuration access port
    input wire [ICAP_W-1:0] icap_o,
    output reg icap_csib,
    output reg icap_rdwrb,
    output reg [ICAP_W-1:0] icap_i,
    output reg icap_request,
    input wire icap_grant,
    // scan checker
    input wire fecc_crcerr,
    input wire fecc_eccerr,
    input wire fecc_eccerrsingle,
    input wire fecc_syndromevalid,
    input wire [12:0] fecc_syndrome,
    input wire [FAR_W-1:0] fecc_far,
    input wire [4:0] fecc_synbit,
    input wire [6:0] fecc_synword,
    // status
    output wire status_heartbeat,
    output reg status_initialization,
    output reg status_observation,
    output reg status_correction,
    output reg status_classification,
    output reg status_injection,
    output reg status_essential,
    output reg status_uncorrectable
);

// ----------------------------------------------------------------------
// states, one-hot
// ----------------------------------------------------------------------
localparam ST_INIT = 7'b000_0001;
localparam ST_OBS = 7'b000_0010;
localparam ST_CORR = 7'b000_0100;
localparam ST_CLASS = 7'b000_1000;
localparam ST_INJ = 7'b001_0000;
localparam ST_IDLE = 7'b010_0000;
localparam ST_HALT = 7'b100_0000;

// indicator code {inj, class, corr, obs, init} for a state
function [4:0] ind_code;
    input [6:0] st;
    begin
        case (st)
            ST_INIT: ind_code = 5'h01;
            ST_OBS: ind_code = 5'h02;
            ST_CORR: ind_code = 5'h04;
            ST_CLASS: ind_code = 5'h08;
            ST_INJ: ind_code = 5'h10;
            ST_IDLE: ind_code = `SSC_ZERO_ST; // R18
            ST_HALT: ind_code = 5'h1F; // R19
            default: ind_code = 5'h1F;
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// declarations
// ----------------------------------------------------------------------
wire srst; // internal synchronous reset
reg [6:0] state_reg; // controller state
reg [6:0] state_next; // state after this edge
reg [3:0] cnt_reg; // step within a state
reg [1:0] ctrl_reg; // correction and classification enables
reg [ICAP_W-1:0] inj_reg; // injection address word
reg [31:0] elo_reg; // lowest essential frame address
reg [31:0] ehi_reg; // highest essential frame address
reg [ICAP_W-1:0] init_word_reg; // word read during initialization
reg [FAR_W-1:0] far_reg; // captured frame address
reg [6:0] word_reg; // captured word index
reg [4:0] bit_reg; // captured bit index
reg [12:0] syn_reg; // captured syndrome
reg fixable_reg; // error is a single correctable bit
reg pend_reg; // detection seen, details being queried
// command strobes from a write to the command register
wire wr_cmd = reg_wr && (reg_addr == `SSC_A_CMD);
wire cmd_idle = wr_cmd && reg_wdata[`SSC_B_GO_IDLE];
wire cmd_resume = wr_cmd && reg_wdata[`SSC_B_RESUME];
wire cmd_inject = wr_cmd && reg_wdata[`SSC_B_INJECT];
// frame address widened for the essential range compare
wire [31:0] far_ext = {{(32-FAR_W){1'b0}}, far_reg};
wire in_range = (far_ext >= elo_reg) && (far_ext <= ehi_reg);

// ----------------------------------------------------------------------
// leaf blocks
// ----------------------------------------------------------------------
ssc_rst_gen #(.RST_LEN(RST_LEN)) u_rst (
    .clk_sys(clk_sys),
    .rst(rst),
    .srst_reg(srst)
);

// enable is the registered observation indicator
ssc_beat #(.PERIOD(HB_PERIOD)) u_beat (
    .clk_sys(clk_sys),
    .rst(rst),
    .srst(srst),
    .enable(status_observation),
    .beat_reg(status_heartbeat)
);

// ----------------------------------------------------------------------
// next state
// ----------------------------------------------------------------------
// correction and classification exits wait for the step count, so flags settle one edge before
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_INIT: begin
            if (icap_grant && cnt_reg == RD_LAT[3:0]) // R7
                state_next = ST_OBS;
        end
        ST_OBS: begin
            if (pend_reg)
                state_next = ST_CORR;
            else if (cmd_idle)
                state_next = ST_IDLE;
        end
        ST_CORR: begin
            if (cnt_reg == 4'h3) // R17
                state_next = ST_CLASS;
        end
        ST_CLASS: begin
            if (cnt_reg == 4'h1) begin // R16
                if (status_uncorrectable && status_essential)
                    state_next = ST_HALT;
                else
                    state_next = ST_OBS;
            end
        end
        ST_INJ: begin
            if (cnt_reg == 4'h1) // R15
                state_next = ST_IDLE;
        end
        ST_IDLE: begin
            if (cmd_inject)
                state_next = ST_INJ; // R20
            else if (cmd_resume)
                state_next = ST_OBS;
        end
        ST_HALT: state_next = ST_HALT;
        default: state_next = ST_HALT;
    endcase
end

// ----------------------------------------------------------------------
// state, indicators and port drive
// ----------------------------------------------------------------------
// indicators follow state_next: same edge as state, from flip-flops
always @(posedge clk_sys or posedge rst) begin // R2
    if (rst) begin
        state_reg <= ST_INIT;
        cnt_reg <= `SSC_CNT_ZERO;
        {status_injection, status_classification, status_correction,
            status_observation, status_initialization} <= 5'h01;
        status_essential <= 1'b0;
        status_uncorrectable <= 1'b0;
        icap_csib <= 1'b1;
        icap_rdwrb <= 1'b1;
        icap_i <= `SSC_WORD_RST;
        icap_request <= 1'b0;
        init_word_reg <= `SSC_WORD_RST;
        far_reg <= {FAR_W{1'b0}};
        word_reg <= 7'h00;
        bit_reg <= 5'h00;
        syn_reg <= 13'h0000;
        fixable_reg <= 1'b0;
        pend_reg <= 1'b0;
    end else if (srst) begin // R1
        state_reg <= ST_INIT;
        cnt_reg <= `SSC_CNT_ZERO;
        {status_injection, status_classification, status_correction,
            status_observation, status_initialization} <= 5'h01;
        status_essential <= 1'b0;
        status_uncorrectable <= 1'b0;
        icap_csib <= 1'b1;
        icap_rdwrb <= 1'b1;
        icap_i <= `SSC_WORD_RST;
        init_word_reg <= `SSC_WORD_RST;
        pend_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        // R11 R12 R13 R14 R15 R21
        {status_injection, status_classification, status_correction,
            status_observation, status_initialization} <=
            ind_code(state_next);
        cnt_reg <= (state_next != state_reg) ? `SSC_CNT_ZERO
                                             : cnt_reg + 4'h1;
        icap_csib <= 1'b1; // deselected unless a step below drives it
        icap_rdwrb <= 1'b1;
        icap_request <= 1'b0; // R6
        case (state_reg)
            ST_INIT: begin
                if (!icap_grant)
                    cnt_reg <= `SSC_CNT_ZERO; // R7
                else if (cnt_reg == 4'h0)
                    icap_csib <= 1'b0; // R4
                else if (cnt_reg == RD_LAT[3:0])
                    init_word_reg <= icap_o; // R3
            end
            ST_OBS: begin
                // first cycle of a detection: query details, stay here
                if (!pend_reg && (fecc_crcerr ||
                        (fecc_eccerr && fecc_syndromevalid))) begin
                    pend_reg <= 1'b1; // R12
                    far_reg <= fecc_far; // R8
                    word_reg <= fecc_synword;
                    bit_reg <= fecc_synbit;
                    syn_reg <= fecc_syndrome;
                    fixable_reg <= !fecc_crcerr && fecc_eccerrsingle;
                end else begin
                    pend_reg <= 1'b0;
                end
            end
            ST_CORR: begin
                // two back-to-back words: frame, then syndrome detail
                if (fixable_reg && ctrl_reg[`SSC_B_CORR_EN] &&
                        cnt_reg < 4'h2) begin
                    icap_csib <= 1'b0; // R4
                    icap_rdwrb <= 1'b0;
                    icap_i <= (cnt_reg == 4'h0) ? // R3
                        {{(ICAP_W-FAR_W){1'b0}}, far_reg} :
                        {{(ICAP_W-25){1'b0}}, syn_reg, word_reg, bit_reg};
                end
                if (cnt_reg == 4'h2) // R17
                    status_uncorrectable <=
                        !(fixable_reg && ctrl_reg[`SSC_B_CORR_EN]);
            end
            ST_CLASS: begin
                if (cnt_reg == 4'h0) // R16
                    status_essential <= ctrl_reg[`SSC_B_CLASS_EN] ?
                        in_range : 1'b1;
            end
            ST_INJ: begin
                if (cnt_reg == 4'h0) begin
                    icap_csib <= 1'b0; // R4
                    icap_rdwrb <= 1'b0;
                    icap_i <= inj_reg;
                end
            end
            default: icap_csib <= 1'b1; // idle and halt leave port alone
        endcase
    end
end

// ----------------------------------------------------------------------
// software registers
// ----------------------------------------------------------------------
// essential range defaults to all, so unset classification is safe
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        ctrl_reg <= `SSC_CTRL_RST;
        inj_reg <= `SSC_WORD_RST;
        elo_reg <= 32'h0000_0000;
        ehi_reg <= 32'hFFFF_FFFF;
    end else if (srst) begin
        ctrl_reg <= `SSC_CTRL_RST;
    end else if (reg_wr) begin
        case (reg_addr)
            `SSC_A_CTRL: ctrl_reg <= reg_wdata[1:0];
            `SSC_A_INJ: inj_reg <= reg_wdata;
            `SSC_A_ELO: elo_reg <= reg_wdata;
            `SSC_A_EHI: ehi_reg <= reg_wdata;
            default: ctrl_reg <= ctrl_reg; // others ignored
        endcase
    end
end

// ----------------------------------------------------------------------
// read port
// ----------------------------------------------------------------------
// data stand only in the cycle after the strobe; unmapped reads zero
always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
        reg_rdata <= `SSC_WORD_RST;
    end else if (!reg_rd) begin
        reg_rdata <= `SSC_WORD_RST;
    end else begin
        case (reg_addr)
            `SSC_A_CTRL: reg_rdata <= {30'h0000_0000, ctrl_reg};
            `SSC_A_INJ: reg_rdata <= inj_reg;
            `SSC_A_STAT: reg_rdata <= {25'h000_0000, status_essential,
                status_uncorrectable, status_injection,
                status_classification, status_correction,
                status_observation, status_initialization};
            `SSC_A_FAR: reg_rdata <= far_ext;
            `SSC_A_ELO: reg_rdata <= elo_reg;
            `SSC_A_EHI: reg_rdata <= ehi_reg;
            `SSC_A_INIT: reg_rdata <= init_word_reg;
            default: reg_rdata <= `SSC_WORD_RST;
        endcase
    end
end

endmodule

/* test/ssc_icap_model.sv */
// Purpose: behavioural configuration access port for the status bench
// Assumes: fed by the same clock as the controller
// Notes:   read data stand only for the read-latency window, else inverted
`timescale 1ns/1ps
module ssc_icap_model #(
    // power-up word returned to a read; value is arbitrary
    parameter logic [31:0] INIT_WORD = 32'h5A5A_0F0F
) (
    // port clock, shared with the controller
    input wire clk_sys,
    // port controls and data, driven by the controller
    input wire icap_csib,
    input wire icap_rdwrb,
    input wire [31:0] icap_i,
    // port read data back to the controller
    output logic [31:0] icap_o
);
    logic [1:0] hold_reg = 2'h0; // read-data window left
    logic [31:0] wr_log[$]; // every word written, for the bench
    // ------------------------------------------------------------
    // port access decode
    // ------------------------------------------------------------
    // one rising-edge clock for both ends, no second domain
    always @(posedge clk_sys) begin
        if (!icap_csib && icap_rdwrb) begin
            hold_reg <= 2'h3;
        end else if (hold_reg != 2'h0) begin
            hold_reg <= hold_reg - 2'h1;
        end
        if (!icap_csib && !icap_rdwrb) begin
            wr_log.push_back(icap_i);
        end
    end
    // outside the window show the inverse, so a late capture is seen
    assign icap_o = (hold_reg != 2'h0) ? INIT_WORD : ~INIT_WORD;
endmodule

/* test/ssc_props.sv */
// Purpose: port-level checks on state indicators and port strobes
// Assumes: bound to ssc_top, one clock, rst disables every check
// Notes:   heartbeat gap counted in helper logic, not by repetition
`timescale 1ns/1ps
module ssc_props (
    // clock and global set/reset
    input wire clk_sys,
    input wire rst,
    // port and scan inputs
    input wire icap_csib,
    input wire icap_rdwrb,
    input wire icap_grant,
    input wire fecc_crcerr,
    // status outputs
    input wire status_heartbeat,
    input wire status_initialization,
    input wire status_observation,
    input wire status_correction,
    input wire status_classification,
    input wire status_injection,
    input wire status_essential,
    input wire status_uncorrectable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire [4:0] st = {status_injection, status_classification,
        status_correction, status_observation, status_initialization};
    logic [7:0] gap_reg; // observing cycles since the last pulse
    logic done_reg; // initialization has finished once
    // gap restarts outside observation, where the pulse is free
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gap_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            gap_reg <= (status_heartbeat || !status_observation) ?
                8'h00 : gap_reg + 8'h01;
            if ($fell(status_initialization)) begin
                done_reg <= 1'b1;
            end
        end
    end
    property p_hb_gap; status_observation |-> gap_reg < 8'h80; endproperty
    a_hb_gap: assert property (p_hb_gap)
        else $error("heartbeat gap too long");
    property p_hb_pulse; status_heartbeat |=> !status_heartbeat; endproperty
    a_hb_pulse: assert property (p_hb_pulse)
        else $error("heartbeat longer than one cycle");
    property p_code; $onehot(st) || st == 5'h00 || st == 5'h1F; endproperty
    a_code: assert property (p_code)
        else $error("illegal state indicator code");
    property p_once; status_initialization && done_reg |-> st == 5'h1F;
    endproperty
    a_once: assert property (p_once)
        else $error("initialization seen twice");
    property p_grant; status_initialization && !icap_grant |=>
        status_initialization; endproperty
    a_grant: assert property (p_grant)
        else $error("left initialization without grant");
    property p_rd; !icap_csib && icap_rdwrb |-> status_initialization;
    endproperty
    a_rd: assert property (p_rd)
        else $error("port read outside initialization");
    property p_wr; !icap_csib && !icap_rdwrb |->
        status_correction || status_injection; endproperty
    a_wr: assert property (p_wr)
        else $error("port write outside correction or injection");
    property p_ess; $changed(status_essential) |->
        $past(status_classification); endproperty
    a_ess: assert property (p_ess)
        else $error("essential flag moved outside classification");
    property p_unc; $changed(status_uncorrectable) |->
        $past(status_correction); endproperty
    a_unc: assert property (p_unc)
        else $error("uncorrectable flag moved outside correction");
    property p_query; status_observation && fecc_crcerr |=>
        status_observation; endproperty
    a_query: assert property (p_query)
        else $error("observation dropped during query");
    c_idle: cover property (st == 5'h00);
    c_halt: cover property (st == 5'h1F);
    c_inj: cover property ($rose(status_injection));
    c_cls: cover property ($rose(status_classification));
endmodule
bind ssc_top ssc_props u_props (.clk_sys(clk_sys), .rst(rst),
    .icap_csib(icap_csib), .icap_rdwrb(icap_rdwrb),
    .icap_grant(icap_grant), .fecc_crcerr(fecc_crcerr),
    .status_heartbeat(status_heartbeat),
    .status_initialization(status_initialization),
    .status_observation(status_observation),
    .status_correction(status_correction),
    .status_classification(status_classification),
    .status_injection(status_injection),
    .status_essential(status_essential),
    .status_uncorrectable(status_uncorrectable));

/* test/ssc_top_tb.sv */
// Purpose: scenario bench for the soft error status controller
// Assumes: register port answers one cycle after the strobe
// Notes:   expected words are built here from the field layout
`timescale 1ns/1ps
module ssc_top_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, icap_grant = 1'b0;
    logic crc = 1'b0, ecc = 1'b0, sgl = 1'b0, sv = 1'b0; // scan strobes
    logic [12:0] syn = 13'h0000;
    logic [25:0] far = 26'h000_0000;
    logic [4:0] sbit = 5'h00;
    logic [6:0] sword = 7'h00;
    wire [31:0] reg_rdata, icap_o, icap_i;
    wire icap_csib, icap_rdwrb, hb, s_init, s_obs, s_cor, s_cls, s_inj;
    wire s_ess, s_unc;
    wire [4:0] st = {s_inj, s_cls, s_cor, s_obs, s_init};
    int bad_count = 0;
    int total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    ssc_icap_model u_icap (.clk_sys(clk_sys), .icap_csib(icap_csib),
        .icap_rdwrb(icap_rdwrb), .icap_i(icap_i), .icap_o(icap_o));
    // request output left open on purpose
    ssc_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .icap_o(icap_o), .icap_csib(icap_csib),
        .icap_rdwrb(icap_rdwrb), .icap_i(icap_i), .icap_request(),
        .icap_grant(icap_grant), .fecc_crcerr(crc), .fecc_eccerr(ecc),
        .fecc_eccerrsingle(sgl), .fecc_syndromevalid(sv),
        .fecc_syndrome(syn), .fecc_far(far), .fecc_synbit(sbit),
        .fecc_synword(sword), .status_heartbeat(hb),
        .status_initialization(s_init), .status_observation(s_obs),
        .status_correction(s_cor), .status_classification(s_cls),
        .status_injection(s_inj), .status_essential(s_ess),
        .status_uncorrectable(s_unc));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait for a state code; running out ends the run
    task automatic wait_st(input logic [4:0] e, input int n);
        for (int i = 0; i < n && st !== e; i++) @(posedge clk_sys);
        chk("state", e, st);
        if (st !== e) finish_test();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset with grant withheld, then initialization completes
    task automatic t_reset;
        logic [31:0] d;
        rst <= 1'b1;
        icap_grant <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk("rst_st", 32'h0000_0001, st);
        chk("rst_cs", 32'h0000_0001, icap_csib);
        rst <= 1'b0;
        repeat (40) @(posedge clk_sys);
        chk("hold_st", 32'h0000_0001, st);
        icap_grant <= 1'b1;
        wait_st(5'h02, 20);
        rd(8'h1C, d);
        chk("init_word", u_icap.INIT_WORD, d);
        rd(8'h24, d);
        chk("unmapped", 32'h0000_0000, d);
        rd(8'h00, d);
        chk("ctrl_rst", 32'h0000_0003, d);
        rd(8'h18, d);
        chk("ehi_rst", 32'hFFFF_FFFF, d);
    endtask
    // pulse looked for only while observing, it is free elsewhere
    task automatic t_beat;
        for (int i = 0; i < 130 && hb !== 1'b1; i++) @(posedge clk_sys);
        chk("beat", 32'h0000_0001, hb);
        @(posedge clk_sys);
    endtask
    // idle, one injection, resume
    task automatic t_inject;
        logic [31:0] d;
        int n;
        wr(8'h04, 32'h0000_0001);
        wait_st(5'h00, 6);
        wr(8'h08, 32'hC0DE_1234);
        rd(8'h08, d);
        chk("inj_reg", 32'hC0DE_1234, d);
        n = u_icap.wr_log.size();
        wr(8'h04, 32'h0000_0004);
        wait_st(5'h10, 4);
        wait_st(5'h00, 8);
        chk("inj_n", 32'h0000_0001, u_icap.wr_log.size() - n);
        chk("inj_w", 32'hC0DE_1234, u_icap.wr_log[n]);
        wr(8'h04, 32'h0000_0002);
        wait_st(5'h02, 6);
    endtask
    // one detection through correction and classification
    task automatic t_detect(input logic c, input logic [25:0] f,
        input logic [4:0] fin, input logic u, e, input int wn);
        logic [31:0] d;
        int n;
        n = u_icap.wr_log.size();
        far <= f;
        syn <= 13'h0ABC;
        sbit <= 5'h05;
        sword <= 7'h21;
        {crc, ecc, sgl, sv} <= {c, 1'b1, !c, 1'b1};
        @(posedge clk_sys);
        {crc, ecc, sgl, sv} <= 4'h0;
        wait_st(5'h04, 8);
        wait_st(5'h08, 12);
        wait_st(fin, 12);
        rd(8'h0C, d);
        chk("stat", {25'h0, e, u, fin}, d);
        chk("cor_n", wn, u_icap.wr_log.size() - n);
        if (wn == 2) begin
            chk("cor_w0", {6'h00, f}, u_icap.wr_log[n]);
            chk("cor_w1", {7'h00, 13'h0ABC, 7'h21, 5'h05},
                u_icap.wr_log[n + 1]);
        end
    endtask
    initial begin
        t_reset();
        t_beat();
        t_inject();
        t_detect(1'b0, 26'h000_0123, 5'h02, 1'b0, 1'b1, 2);
        wr(8'h14, 32'h0000_0100);
        wr(8'h18, 32'h0000_0200);
        t_detect(1'b1, 26'h000_0300, 5'h02, 1'b1, 1'b0, 0);
        wr(8'h00, 32'h0000_0001);
        t_detect(1'b0, 26'h000_0300, 5'h02, 1'b0, 1'b1, 2);
        wr(8'h00, 32'h0000_0002);
        t_detect(1'b0, 26'h000_0150, 5'h1F, 1'b1, 1'b1, 0);
        t_reset();
        finish_test();
    end
endmodule
